// file: core/rls_ctrl.sv
// Write-only regulator and light-sensor control registers behind a serial bus slave.
// Assumes open-drain SCL/SDA resolved outside; a sensor reading arrives on READING_I.
//
// Function
// [R1] Register 24h bits 7..4 hold the regulator A level code.
// [R2] Register 24h bits 3..0 hold the regulator B level code.
// [R3] Register 25h bits 7..4 hold the regulator C level code.
// [R4] Register 25h bits 3..0 hold the regulator D level code.
// [R5] Codes 0 to 15 map to 1.2 V up to 3.3 V ascending.
// [R6] Both level registers reset to zero, giving 1.2 V everywhere.
// [R7] Register 26h bits 0..3 switch regulators A..D on; reset is zero.
// [R8] Host writes zeros into upper four bits of the enable register.
// [R9] Offset trim corrects the sensor reading from -8 to +7 steps.
// [R10] Sensor enable bit in 0Eh switches the light sensor on.
// [R11] Bias enable bit in 0Fh turns the sensor bias supply on.
// [R12] Test-mode bit in 0Fh measures the raw offset, without trim.
// [R13] Linear sensor with conversion bit set gets logarithmic conversion.
// [R14] Four internal load resistor pairs, or an external resistor, selectable.
// [R15] Host clears test mode and writes the negated offset as trim.
// [R16] A write changes only the addressed register.
`timescale 1ns/1ps
module rls_ctrl
  import rls_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // Serial bus
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  // Sensor reading path
  input  wire logic [7:0]  READING_I,
  output logic      [7:0]  READING_O,
  // Configuration outputs
  output rls_reg_t         REG_CFG_O,
  output logic      [11:0] REG_MV_O [4],
  output rls_sensor_t      SENSOR_CFG_O
);

  // ****************************************************************
  // Pin synchronisation and bus events
  // ****************************************************************
  logic       scl_s, sda_s, scl_q, sda_q;
  logic       scl_rise, scl_fall, bus_start, bus_stop;

  rls_sync #(.W(2)) u_sync (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   ({SCL_I, SDA_I}),
    .q_o   ({scl_s, sda_s})
  );

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

  // ****************************************************************
  // Bus slave state machine
  // ****************************************************************
  rls_state_t state;
  logic [2:0] bit_cnt;
  logic [7:0] shifter, next_shifter, ptr, wr_addr, wr_data;
  logic       ack_want, ack_drive, wr_stb, byte_done;

  assign next_shifter = {shifter[6:0], sda_s};
  assign byte_done    = scl_rise && bit_cnt == LAST_BIT;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state     <= ST_IDLE;
      bit_cnt   <= '0;
      shifter   <= '0;
      ptr       <= '0;
      ack_want  <= 1'b0;
      ack_drive <= 1'b0;
      SDA_OE_O  <= 1'b0;
      SDA_O     <= 1'b0;  // Open-drain: only ever pulls low
      wr_stb    <= 1'b0;
      wr_addr   <= '0;
      wr_data   <= '0;
    end else begin
      wr_stb <= 1'b0;
      if (bus_start) begin
        state     <= ST_ADDR;
        bit_cnt   <= '0;
        ack_drive <= 1'b0;
        SDA_OE_O  <= 1'b0;
      end else if (bus_stop) begin
        state     <= ST_IDLE;
        ack_drive <= 1'b0;
        SDA_OE_O  <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE, ST_SKIP: begin
          end
          ST_ADDR, ST_PTR, ST_DATA: begin
            if (scl_rise) begin
              shifter <= next_shifter;
              bit_cnt <= bit_cnt + 3'h1;
            end
            if (byte_done) begin
              unique case (state)
                ST_ADDR: begin
                  // Only write transfers to this address are answered
                  ack_want <= next_shifter[7:1] == DEV_ADDR && !next_shifter[0];
                  state    <= ST_ADDR_ACK;
                end
                ST_PTR: begin
                  ack_want <= 1'b1;
                  ptr      <= next_shifter;
                  state    <= ST_PTR_ACK;
                end
                default: begin
                  ack_want <= 1'b1;
                  wr_stb   <= 1'b1;
                  wr_addr  <= ptr;
                  wr_data  <= next_shifter;
                  ptr      <= ptr + 8'h01;
                  state    <= ST_DATA_ACK;
                end
              endcase
            end
          end
          ST_ADDR_ACK, ST_PTR_ACK, ST_DATA_ACK: begin
            if (scl_fall) begin
              if (!ack_drive) begin
                ack_drive <= 1'b1;
                SDA_OE_O  <= ack_want;
              end else begin
                ack_drive <= 1'b0;
                SDA_OE_O  <= 1'b0;
                bit_cnt   <= '0;
                if (!ack_want) begin
                  state <= ST_SKIP;
                end else if (state == ST_ADDR_ACK) begin
                  state <= ST_PTR;
                end else begin
                  state <= ST_DATA;
                end
              end
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Register bank
  // ****************************************************************
  logic [7:0] sensor_cfg0;
  logic [7:0] sensor_cfg1;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_CFG_O.regulator_a_level <= RST_REG_LEVELS[7:4];  // see [R6]
      REG_CFG_O.regulator_b_level <= RST_REG_LEVELS[3:0];
      REG_CFG_O.regulator_c_level <= RST_REG_LEVELS[7:4];
      REG_CFG_O.regulator_d_level <= RST_REG_LEVELS[3:0];
      {REG_CFG_O.regulator_d_on, REG_CFG_O.regulator_c_on,
       REG_CFG_O.regulator_b_on, REG_CFG_O.regulator_a_on} <= RST_REG_ON;
      sensor_cfg0 <= RST_SENSOR_CFG;
      sensor_cfg1 <= RST_SENSOR_CFG;
    end else if (wr_stb) begin
      // Each offset loads its own storage only; unmapped offsets are dropped, see [R16]
      unique case (wr_addr)
        OFS_REG_AB: begin
          REG_CFG_O.regulator_a_level <= wr_data[HI_LEVEL_LSB+:4];  // see [R1]
          REG_CFG_O.regulator_b_level <= wr_data[3:0];              // see [R2]
        end
        OFS_REG_CD: begin
          REG_CFG_O.regulator_c_level <= wr_data[HI_LEVEL_LSB+:4];  // see [R3]
          REG_CFG_O.regulator_d_level <= wr_data[3:0];              // see [R4]
        end
        OFS_REG_EN: begin
          // Upper bits are not stored, see [R7] [R8]
          {REG_CFG_O.regulator_d_on, REG_CFG_O.regulator_c_on,
           REG_CFG_O.regulator_b_on, REG_CFG_O.regulator_a_on} <= wr_data[3:0];
        end
        OFS_SENSOR_CFG0: sensor_cfg0 <= wr_data;
        OFS_SENSOR_CFG1: sensor_cfg1 <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Decoded outputs
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SENSOR_CFG_O <= '0;
    end else begin
      SENSOR_CFG_O.light_sensor_on       <= sensor_cfg0[CFG0_SENSOR_ON];        // see [R10]
      SENSOR_CFG_O.sensor_type_select    <= sensor_cfg0[CFG0_TYPE];
      SENSOR_CFG_O.log_conversion_select <= sensor_cfg0[CFG0_LOG_CONV];
      SENSOR_CFG_O.log_conversion_active <= !sensor_cfg0[CFG0_TYPE]
                                            && sensor_cfg0[CFG0_LOG_CONV];      // see [R13]
      SENSOR_CFG_O.load_pair_select      <= sensor_cfg0[CFG0_LOAD_LSB+:2];      // see [R14]
      SENSOR_CFG_O.external_load_select  <= sensor_cfg0[CFG0_EXT_LOAD];         // see [R14]
      SENSOR_CFG_O.sensor_bias_on        <= sensor_cfg1[CFG1_BIAS_ON];          // see [R11]
      SENSOR_CFG_O.offset_test_mode      <= sensor_cfg1[CFG1_TEST_MODE];        // see [R12]
      SENSOR_CFG_O.sensor_offset_trim    <= sensor_cfg1[CFG1_TRIM_LSB+:4];
    end
  end

  logic [3:0] level_code [4];
  assign level_code[0] = REG_CFG_O.regulator_a_level;
  assign level_code[1] = REG_CFG_O.regulator_b_level;
  assign level_code[2] = REG_CFG_O.regulator_c_level;
  assign level_code[3] = REG_CFG_O.regulator_d_level;

  genvar r;
  generate
    for (r = 0; r < 4; r++) begin : g_mv
      always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
          REG_MV_O[r] <= LEVEL_MV[0];
        end else begin
          REG_MV_O[r] <= LEVEL_MV[level_code[r]];  // see [R5]
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Offset-corrected reading
  // ****************************************************************
  logic signed [9:0] trimmed;
  assign trimmed = $signed({2'b00, READING_I})
                 + 10'($signed(sensor_cfg1[CFG1_TRIM_LSB+:4]));

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      READING_O <= '0;
    end else if (sensor_cfg1[CFG1_TEST_MODE]) begin
      READING_O <= READING_I;  // see [R12]
    end else if (trimmed < 0) begin
      READING_O <= '0;         // see [R9]
    end else if (trimmed > $signed(READING_MAX)) begin
      READING_O <= READING_MAX[7:0];
    end else begin
      READING_O <= trimmed[7:0];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_ab_level_load: assert property (@(posedge CLK_I) disable iff (RST_I)  // see [R1]
    wr_stb && wr_addr == OFS_REG_AB |=> REG_CFG_O.regulator_a_level == $past(wr_data[7:4]))
    else $error("regulator A level not loaded");
  chk_b_level_load: assert property (@(posedge CLK_I) disable iff (RST_I)  // see [R2]
    wr_stb && wr_addr == OFS_REG_AB |=> REG_CFG_O.regulator_b_level == $past(wr_data[3:0]))
    else $error("regulator B level not loaded");
  chk_cd_level_load: assert property (@(posedge CLK_I) disable iff (RST_I)  // see [R3]
    wr_stb && wr_addr == OFS_REG_CD
    |=> {REG_CFG_O.regulator_c_level, REG_CFG_O.regulator_d_level} == $past(wr_data))
    else $error("regulator C/D levels not loaded");
  chk_mv_follow: assert property (@(posedge CLK_I) disable iff (RST_I)  // see [R5]
    ##1 REG_MV_O[0] == LEVEL_MV[$past(REG_CFG_O.regulator_a_level)])
    else $error("regulator A voltage does not follow code");
  chk_enable_load: assert property (@(posedge CLK_I) disable iff (RST_I)  // see [R7]
    wr_stb && wr_addr == OFS_REG_EN |=> REG_CFG_O.regulator_a_on == $past(wr_data[0])
    && REG_CFG_O.regulator_d_on == $past(wr_data[3]))
    else $error("enable bits not loaded");
  chk_write_isolated: assert property (@(posedge CLK_I) disable iff (RST_I)  // see [R16]
    wr_stb && wr_addr != OFS_REG_AB && wr_addr != OFS_REG_CD |=> $stable(level_code[0])
    && $stable(level_code[3]))
    else $error("levels changed by another offset");
  chk_log_conv: assert property (@(posedge CLK_I) disable iff (RST_I)  // see [R13]
    SENSOR_CFG_O.log_conversion_active == (!SENSOR_CFG_O.sensor_type_select
    && SENSOR_CFG_O.log_conversion_select))
    else $error("log conversion decode wrong");
  chk_test_raw: assert property (@(posedge CLK_I) disable iff (RST_I)  // see [R12]
    sensor_cfg1[CFG1_TEST_MODE] |=> READING_O == $past(READING_I))
    else $error("test mode reading was trimmed");
  chk_ack_release: assert property (@(posedge CLK_I) disable iff (RST_I)  // see [R16]
    SDA_OE_O |-> state inside {ST_ADDR_ACK, ST_PTR_ACK, ST_DATA_ACK})
    else $error("SDA driven outside acknowledge");

endmodule

// file: core/rls_sync.sv
// Two-stage synchroniser, one per bit.
// Assumes the inputs are asynchronous to CLK_I.
`timescale 1ns/1ps
module rls_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          meta[g] <= 1'b1;
          q_o[g]  <= 1'b1;
        end else begin
          meta[g] <= d_i[g];
          q_o[g]  <= meta[g];
        end
      end
    end
  endgenerate
endmodule

// file: shared/rls_pkg.sv
// Package of the regulator and light-sensor control block.
// Assumes one 200 MHz clock domain; the serial bus pins are synchronised in the core.
package rls_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_SENSOR_CFG0 = 8'h0e;
  localparam logic [7:0] OFS_SENSOR_CFG1 = 8'h0f;
  localparam logic [7:0] OFS_REG_AB      = 8'h24;
  localparam logic [7:0] OFS_REG_CD      = 8'h25;
  localparam logic [7:0] OFS_REG_EN      = 8'h26;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [7:0] RST_REG_LEVELS  = 8'h00;
  localparam logic [3:0] RST_REG_ON      = 4'h0;
  localparam logic [7:0] RST_SENSOR_CFG  = 8'h00;
  localparam int         HI_LEVEL_LSB    = 4;
  localparam int         CFG0_SENSOR_ON  = 0;
  localparam int         CFG0_TYPE       = 1;
  localparam int         CFG0_LOG_CONV   = 2;
  localparam int         CFG0_LOAD_LSB   = 4;
  localparam int         CFG0_EXT_LOAD   = 6;
  localparam int         CFG1_BIAS_ON    = 0;
  localparam int         CFG1_TRIM_LSB   = 1;
  localparam int         CFG1_TEST_MODE  = 7;

  // ****************************************************************
  // Serial bus and reading limits
  // ****************************************************************
  localparam logic [6:0] DEV_ADDR_DEF    = 7'h60;
  localparam logic [2:0] LAST_BIT        = 3'h7;
  localparam logic [9:0] READING_MAX     = 10'h0ff;

  // Output voltage in millivolts, indexed by the four-bit level code
  localparam logic [11:0] LEVEL_MV [16] = '{
    12'd1200, 12'd1300, 12'd1500, 12'd1600, 12'd1800, 12'd2000, 12'd2200, 12'd2500,
    12'd2600, 12'd2700, 12'd2800, 12'd2900, 12'd3000, 12'd3100, 12'd3200, 12'd3300};

  typedef struct packed {
    logic [3:0] regulator_a_level;
    logic [3:0] regulator_b_level;
    logic [3:0] regulator_c_level;
    logic [3:0] regulator_d_level;
    logic       regulator_d_on;
    logic       regulator_c_on;
    logic       regulator_b_on;
    logic       regulator_a_on;
  } rls_reg_t;

  typedef struct packed {
    logic       light_sensor_on;
    logic       sensor_type_select;
    logic       log_conversion_select;
    logic       log_conversion_active;
    logic [1:0] load_pair_select;
    logic       external_load_select;
    logic       sensor_bias_on;
    logic       offset_test_mode;
    logic [3:0] sensor_offset_trim;
  } rls_sensor_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK, ST_DATA, ST_DATA_ACK, ST_SKIP
  } rls_state_t;

endpackage

// file: test/rls_host_model.sv
// Serial bus host model that writes control registers of the block.
// Assumes SDA is open drain with a pull-up resolved by the bench.
`timescale 1ns/1ps
module rls_host_model (
  // Clock
  input  wire logic clk_i,
  // Serial bus
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Data moves mid-way through the low phase so it never moves under a high clock
  task automatic put_bit(input logic b, output logic seen);
    wait_clk(4);
    sda_o = b;
    wait_clk(4);
    scl_o = 1'b1;
    wait_clk(4);
    seen = sda_line_i;
    wait_clk(4);
    scl_o = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] v, inout logic acked);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], seen);
    end
    put_bit(1'b1, seen);
    acked = acked & ~seen;
  endtask

  // START, address with direction bit, pointer, one or two data bytes, STOP
  task automatic write_seq(input logic [6:0] dev, input logic rd, input logic [7:0] ptr,
                           input logic [7:0] d0, input logic [7:0] d1,
                           input int n, output logic acked);
    acked = 1'b1;
    wait_clk(4);
    sda_o = 1'b0;
    wait_clk(8);
    scl_o = 1'b0;
    put_byte({dev, rd}, acked);
    if (acked) begin
      put_byte(ptr, acked);
      put_byte(d0, acked);
      if (n > 1) begin
        put_byte(d1, acked);
      end
    end
    wait_clk(4);
    sda_o = 1'b0;
    wait_clk(4);
    scl_o = 1'b1;
    wait_clk(8);
    sda_o = 1'b1;
    wait_clk(8);
  endtask
endmodule

// file: test/tb_rls_ctrl.sv
// Self-checking bench of the regulator and light-sensor control block.
// Assumes the host model drives the serial bus; SDA has a pull-up.
`timescale 1ns/1ps
module tb_rls_ctrl
  import rls_pkg::*;
;
  logic        clk, rst, scl, host_sda, sda_line, sda_o, sda_oe, ack;
  logic [7:0]  rd_in, rd_out;
  rls_reg_t    reg_cfg;
  logic [11:0] mv [4];
  rls_sensor_t sns;
  int          fail_count, cmp_count, cyc;
  logic [11:0] exp_mv [16] = '{12'd1200, 12'd1300, 12'd1500, 12'd1600, 12'd1800, 12'd2000,
    12'd2200, 12'd2500, 12'd2600, 12'd2700, 12'd2800, 12'd2900, 12'd3000, 12'd3100,
    12'd3200, 12'd3300};
  logic [3:0]  trims [5] = '{4'hd, 4'h7, 4'h8, 4'hf, 4'h7};
  logic [7:0]  raws  [5] = '{8'd100, 8'd250, 8'd5, 8'd0, 8'd100};
  logic [7:0]  outs  [5] = '{8'd97, 8'd255, 8'd0, 8'd0, 8'd107};

  assign sda_line = host_sda & (sda_oe ? sda_o : 1'b1);

  rls_host_model host (.clk_i(clk), .sda_line_i(sda_line), .scl_o(scl), .sda_o(host_sda));

  rls_ctrl #(.DEV_ADDR(DEV_ADDR_DEF)) dut (
    .CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda_line), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .READING_I(rd_in), .READING_O(rd_out), .REG_CFG_O(reg_cfg),
    .REG_MV_O(mv), .SENSOR_CFG_O(sns));

  // ****************************************************************
  // Clock, timeout and closing
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      $display("CHECK FAILED at %0t: run too long", $time);
      close_out();
    end
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic check(input logic [19:0] got, input logic [19:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1,
                    input int n);
    host.write_seq(DEV_ADDR_DEF, 1'b0, ptr, d0, d1, n, ack);
    check(20'(ack), 20'h1, "acknowledge");
  endtask

  task automatic reading(input logic [7:0] v, input logic [7:0] exp);
    rd_in = v;
    repeat (2) @(negedge clk);
    check(20'(rd_out), 20'(exp), "reading");
  endtask

  task automatic reset_state();
    check(20'(reg_cfg), 20'h0, "levels and enables");
    check(20'(sns), 20'h0, "sensor config");
    for (int i = 0; i < 4; i++) begin
      check(20'(mv[i]), 20'd1200, "millivolts");
    end
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    rst = 1'b1;
    rd_in = 8'h00;
    fail_count = 0;
    cmp_count = 0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    reset_state();
    $display("test reset done");

    for (int k = 0; k < 16; k++) begin
      wr(OFS_REG_AB, {4'(k), 4'(15 - k)}, {4'(15 - k), 4'(k)}, 2);
      check(20'(reg_cfg.regulator_a_level), 20'(k), "level a");
      check(20'(reg_cfg.regulator_b_level), 20'(15 - k), "level b");
      check(20'(reg_cfg.regulator_c_level), 20'(15 - k), "level c");
      check(20'(reg_cfg.regulator_d_level), 20'(k), "level d");
      check(20'(mv[0]), 20'(exp_mv[k]), "mv a");
      check(20'(mv[1]), 20'(exp_mv[15 - k]), "mv b");
      check(20'(mv[2]), 20'(exp_mv[15 - k]), "mv c");
      check(20'(mv[3]), 20'(exp_mv[k]), "mv d");
    end
    $display("test levels done");

    wr(OFS_REG_EN, 8'h05, 8'h00, 1);
    check(20'(reg_cfg), 20'hf00f5, "enables a c");
    wr(OFS_REG_EN, 8'h0a, 8'h00, 1);
    check(20'(reg_cfg), 20'hf00fa, "enables b d");
    host.write_seq(7'h61, 1'b0, OFS_REG_EN, 8'h00, 8'h00, 1, ack);
    check(20'(ack), 20'h0, "foreign address refused");
    host.write_seq(DEV_ADDR_DEF, 1'b1, OFS_REG_EN, 8'h0f, 8'h00, 1, ack);
    check(20'(ack), 20'h0, "read direction refused");
    wr(8'h30, 8'hff, 8'h00, 1);
    check(20'(reg_cfg), 20'hf00fa, "untouched by others");
    $display("test enables done");

    wr(OFS_SENSOR_CFG0, 8'h05, 8'h00, 1);
    check(20'(sns.light_sensor_on), 20'h1, "sensor on");
    check(20'(sns.log_conversion_active), 20'h1, "log conversion");
    wr(OFS_SENSOR_CFG0, 8'h77, 8'h00, 1);
    check(20'(sns.log_conversion_active), 20'h0, "log off for log sensor");
    check(20'({sns.sensor_type_select, sns.log_conversion_select}), 20'h3, "type");
    check(20'({sns.external_load_select, sns.load_pair_select}), 20'h7, "load");
    wr(OFS_SENSOR_CFG1, 8'h87, 8'h00, 1);
    check(20'({sns.sensor_bias_on, sns.offset_test_mode}), 20'h3, "bias, test");
    reading(8'd100, 8'd100);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_SENSOR_CFG1, {3'h0, trims[i], 1'b1}, 8'h00, 1);
      check(20'(sns.sensor_offset_trim), 20'(trims[i]), "trim");
      reading(raws[i], outs[i]);
    end
    check(20'(reg_cfg), 20'hf00fa, "regulators kept");
    $display("test sensor done");

    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    reset_state();
    $display("test second reset done");
    close_out();
  end
endmodule
